/* File: ppc_decoder.sv */
`timescale 1ns/1ps
module ppc_decoder
#(
    parameter int unsigned ONESHOT_CYC = ppc_pkg::PPC_ONESHOT_CYC
)
(
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    input  wire logic                             clk_en,
    input  wire logic                             pulse_train_probe,
    input  wire logic [ppc_pkg::PPC_SAMPLE_W-1:0] ecg_sample,
    input  wire logic [3:0]                       s_axi_awaddr,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [3:0]                       s_axi_araddr,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    output ppc_pkg::ppc_setup_s                   setup,
    output logic                                  paddle_limit,
    output logic                                  conv_trigger,
    output logic                                  echo
);
    import ppc_pkg::*;

    typedef enum logic [1:0]
    {
        PPC_TR_IDLE  = 2'b00,
        PPC_TR_COUNT = 2'b01,
        PPC_TR_LATCH = 2'b11
    } ppc_tr_e;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    function automatic logic in_range(input logic [4:0] v, input logic [4:0] lo,
                                      input logic [4:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic [7:0] decode(input logic [4:0] n);
        ppc_setup_s s;
        logic       ok;
        s  = PPC_SETUP_RESET;
        ok = in_range(n, PPC_CNT_LEAD_LO, PPC_CNT_CAL2_HI);
        s.lead = ppc_lead_e'(2'(n - PPC_CNT_LEAD_LO));
        s.cal = in_range(n, PPC_CNT_CAL1_LO, PPC_CNT_CAL1_HI)
              | in_range(n, PPC_CNT_CAL2_LO, PPC_CNT_CAL2_HI);
        s.lead_coil = in_range(n, PPC_CNT_COIL_LO, PPC_CNT_CAL2_HI);
        s.smooth    = in_range(n, PPC_CNT_COIL_LO, PPC_CNT_PADDLE);
        if (n == PPC_CNT_PADDLE)
        begin
            ok            = 1'b1;
            s.lead        = PPC_LEAD_III;
            s.paddles     = 1'b1;
            s.paddle_coil = 1'b1;
        end
        decode = {ok, s};
    endfunction

    // ----------------------------------------------------------------
    // Pin synchroniser and edges
    // ----------------------------------------------------------------
    logic sync1;
    logic sync2;
    logic sync3;
    wire  rise = sync2 & ~sync3;
    wire  fall = ~sync2 & sync3;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end
        else if (clk_en)
        begin
            sync1 <= pulse_train_probe;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // ----------------------------------------------------------------
    // Train counter, one-shot and command latch
    // ----------------------------------------------------------------
    ppc_tr_e                 state;
    logic [PPC_CNT_W-1:0]    count;
    logic [PPC_CNT_W-1:0]    last_count;
    logic [PPC_TMR_W-1:0]    timer;
    logic                    paddle_arm;
    logic [31:0]             ctrl;
    wire  [7:0]              dec      = decode(count);
    wire                     dec_ok   = dec[7];
    wire                     dec_en   = ctrl[PPC_CTRL_DEC_EN];
    wire                     echo_en  = ctrl[PPC_CTRL_ECHO_EN];
    wire                     cnt_full = (count == PPC_CNT_MAX);

    assign conv_trigger = rise && (state == PPC_TR_IDLE) && clk_en;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state      <= PPC_TR_IDLE;
            count      <= '0;
            last_count <= '0;
            timer      <= '0;
            setup      <= PPC_SETUP_RESET;
            paddle_arm <= 1'b0;
            paddle_limit <= 1'b0;
        end
        else if (clk_en)
        begin
            // Paddle limit on next clock pulse
            if (rise)
            begin
                paddle_limit <= paddle_arm;
            end
            case (state)
                PPC_TR_IDLE:
                begin
                    if (rise)
                    begin
                        count <= PPC_CNT_PRESET;
                        timer <= PPC_TMR_W'(ONESHOT_CYC);
                        state <= PPC_TR_COUNT;
                    end
                end
                PPC_TR_COUNT:
                begin
                    if (rise && !cnt_full)
                    begin
                        count <= count + 1'b1;
                    end
                    if (fall)
                    begin
                        timer <= PPC_TMR_W'(ONESHOT_CYC);
                    end
                    else if (timer <= PPC_TMR_W'(1))
                    begin
                        state <= PPC_TR_LATCH;
                    end
                    else
                    begin
                        timer <= timer - 1'b1;
                    end
                end
                PPC_TR_LATCH:
                begin
                    if (dec_ok && dec_en)
                    begin
                        setup      <= ppc_setup_s'(dec[6:0]);
                        paddle_arm <= dec[0];
                    end
                    last_count <= count;
                    state      <= PPC_TR_IDLE;
                end
                default:
                begin
                    state <= PPC_TR_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Track-and-ramp echo
    // ----------------------------------------------------------------
    logic                    ramp_busy;
    logic [PPC_SAMPLE_W-1:0] held;

    ppc_echo_ramp u_ramp
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_en  (clk_en),
        .start   (conv_trigger),
        .enable  (echo_en),
        .sample  (ecg_sample),
        .echo    (echo),
        .busy    (ramp_busy),
        .held    (held)
    );

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    // Address and data are parked separately so either may come first
    logic [3:0]  aw_addr;
    logic        aw_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_full;
    wire         do_wr   = aw_full && w_full && !s_axi_bvalid;
    wire         wr_ctrl = (aw_addr == PPC_OFS_CTRL);
    wire         wr_ok   = wr_ctrl || (aw_addr == PPC_OFS_STATUS) || (aw_addr == PPC_OFS_SAMPLE);
    wire         rd_take = s_axi_arvalid && s_axi_arready;
    wire [31:0]  status  = {14'h0000, echo, ramp_busy, 3'h0, last_count,
                            paddle_limit, setup};
    wire         rd_ok   = (s_axi_araddr == PPC_OFS_CTRL) || (s_axi_araddr == PPC_OFS_STATUS)
                         || (s_axi_araddr == PPC_OFS_SAMPLE);
    wire [31:0]  rd_mux  = (s_axi_araddr == PPC_OFS_CTRL)   ? ctrl
                         : (s_axi_araddr == PPC_OFS_STATUS) ? status
                         : (s_axi_araddr == PPC_OFS_SAMPLE) ? {20'h0_0000, held}
                         : 32'h0000_0000;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready  = !w_full;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full      <= 1'b0;
            aw_addr      <= '0;
            w_full       <= 1'b0;
            w_data       <= '0;
            w_strb       <= '0;
            ctrl         <= PPC_CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= PPC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= PPC_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && !aw_full)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full)
            begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                // Only byte lane 0 of control carries bits; status is read-only
                if (wr_ctrl && w_strb[0])
                begin
                    ctrl <= {30'h0000_0000, w_data[1:0]};
                end
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* File: ppc_decoder_asserts.sv */
`timescale 1ns/1ps
module ppc_decoder_asserts
#(
    parameter int unsigned ONESHOT_CYC = ppc_pkg::PPC_ONESHOT_CYC
)
(
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                clk_en,
    input wire logic                pulse_train_probe,
    input wire logic [11:0]         ecg_sample,
    input wire ppc_pkg::ppc_setup_s setup,
    input wire logic                paddle_limit,
    input wire logic                conv_trigger,
    input wire logic                echo
);
    import ppc_pkg::*;
    // --------------------------------
    // Helper counters
    // --------------------------------
    logic [12:0] since;
    logic [12:0] next_since;
    logic [11:0] samp;
    logic [11:0] next_samp;
    logic [5:0]  ehi;
    logic [5:0]  next_ehi;
    logic [16:0] quiet;
    logic [16:0] next_quiet;
    // Saturate so an echo long after any trigger can never look on time
    assign next_since = !clk_en ? since : conv_trigger ? 13'h0001 : (&since) ? since : since + 13'h0001;
    assign next_samp  = (clk_en && conv_trigger) ? ecg_sample : samp;
    assign next_ehi   = !clk_en ? ehi : echo ? ehi + 6'h01 : 6'h00;
    assign next_quiet = pulse_train_probe ? 17'h0_0000 : (&quiet) ? quiet : quiet + 17'h0_0001;
    always_ff @(posedge aclk)
    begin
        since <= aresetn ? next_since : 13'h1fff;
        samp  <= aresetn ? next_samp : 12'h000;
        ehi   <= aresetn ? next_ehi : 6'h00;
        quiet <= aresetn ? next_quiet : 17'h0_0000;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // --------------------------------
    // Properties
    // --------------------------------
    a_trig_single: assert property (conv_trigger |=> !conv_trigger [*8])
        else $error("second trigger within a train");
    a_echo_delay: assert property ($rose(echo) |-> since == 13'(samp) + 13'h0002)
        else $error("echo delay not sample plus two");
    a_echo_width: assert property ($fell(echo) |-> ehi == 6'(PPC_ECHO_CYC))
        else $error("echo width wrong");
    a_latch_quiet: assert property ($changed(setup) |-> quiet >= 17'(ONESHOT_CYC))
        else $error("setup changed before one-shot expired");
    a_paddle_set: assert property (setup.paddles |-> setup.paddle_coil && setup.smooth
        && setup.lead == PPC_LEAD_III && !setup.cal && !setup.lead_coil)
        else $error("paddle setup inconsistent");
    a_coil_smooth: assert property (setup.lead_coil |-> setup.smooth && !setup.paddle_coil)
        else $error("lead coil without smoothing");
    a_limit_arm: assert property ($rose(paddle_limit) |-> setup.paddles)
        else $error("paddle limit without paddles");
    a_cal_nopad: assert property (setup.cal |-> !setup.paddles && !setup.paddle_coil)
        else $error("cal with paddles");
    c_trig: cover property (conv_trigger);
    c_echo: cover property ($rose(echo));
    c_pad: cover property (setup.paddles);
    c_limit: cover property ($rose(paddle_limit));
endmodule

bind ppc_decoder ppc_decoder_asserts #(.ONESHOT_CYC(ONESHOT_CYC)) ppc_decoder_asserts_i
(
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .pulse_train_probe(pulse_train_probe),
    .ecg_sample(ecg_sample), .setup(setup), .paddle_limit(paddle_limit),
    .conv_trigger(conv_trigger), .echo(echo)
);

/* File: ppc_decoder_tb.sv */
`timescale 1ns/1ps
module ppc_decoder_tb;
    import ppc_pkg::*;
    localparam int unsigned OS = 50;
    logic        aclk, aresetn, clk_en, pin, go, hdone, conv_trigger, echo, paddle_limit;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic        rvalid, rready, arm, have_base;
    logic [1:0]  bresp, rresp, ctrl;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [4:0]  hcount;
    logic [11:0] ecg_sample;
    logic [15:0] meas, base;
    logic [31:0] wdata, rdata;
    ppc_setup_s  setup, exp_su;
    int          error_cnt, num_checks;
    logic [33:0] rq[$];
    logic [11:0] sq[$];

    ppc_decoder #(.ONESHOT_CYC(OS)) ppc_decoder_i
    (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .pulse_train_probe(pin),
        .ecg_sample(ecg_sample), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .setup(setup),
        .paddle_limit(paddle_limit), .conv_trigger(conv_trigger), .echo(echo)
    );
    ppc_host_model ppc_host_model_i
    (
        .aclk(aclk), .go(go), .count(hcount), .echo(echo), .pin(pin), .meas(meas), .done(hdone)
    );

    always #12.5 aclk = ~aclk;

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_word(input logic [33:0] e, input logic [33:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_echo(input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // --------------------------------
    // Bus master
    // --------------------------------
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        rq.push_back({r, 32'h0000_0000});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        if (n >= 100)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
        int n;
        n = 0;
        @(posedge aclk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        if (n >= 100)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask

    function automatic ppc_setup_s dec(input logic [4:0] n);
        ppc_setup_s r;
        r = PPC_SETUP_RESET;
        r.lead = ppc_lead_e'((n == 5'h14) ? 2'h0 : 2'(n - 5'h04));
        r.cal = (n >= 5'h08 && n <= 5'h0b) || (n >= 5'h10 && n <= 5'h13);
        r.lead_coil = (n >= 5'h0c && n <= 5'h13);
        r.paddle_coil = (n == 5'h14);
        r.paddles = (n == 5'h14);
        r.smooth = (n >= 5'h0c);
        return r;
    endfunction

    // One command train, then the latched setup and held sample read back
    task automatic send_cmd(input logic [4:0] n, input logic [11:0] s);
        logic [31:0] st;
        st = 32'h0000_0000;
        @(posedge aclk);
        ecg_sample <= s;
        hcount <= n;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        if (ctrl[1])
            sq.push_back(s);
        st[7] = arm;
        if (ctrl[0] && n >= 5'h04 && n <= 5'h14)
        begin
            exp_su = dec(n);
            arm = (n == 5'h14);
        end
        st[6:0] = exp_su;
        st[12:8] = n;
        repeat (int'(n) * 8 + OS + 360) @(posedge aclk);
        axi_rd(PPC_OFS_STATUS, {PPC_RESP_OKAY, st});
        if (ctrl[1])
            axi_rd(PPC_OFS_SAMPLE, {PPC_RESP_OKAY, 20'h0_0000, s});
    endtask

    // --------------------------------
    // Result monitor
    // --------------------------------
    always @(posedge aclk)
    begin
        if ((rvalid && rready) === 1'b1)
            chk_word(rq.pop_front(), {rresp, rdata});
        if ((bvalid && bready) === 1'b1)
            chk_word(rq.pop_front(), {bresp, 32'h0000_0000});
        if (hdone === 1'b1 && sq.size() == 0)
            chk_echo(~meas, meas);
        else if (hdone === 1'b1 && !have_base)
        begin
            base = meas - 16'(sq.pop_front());
            have_base = 1'b1;
        end
        else if (hdone === 1'b1)
            chk_echo(base, meas - 16'(sq.pop_front()));
    end

    initial
    begin
        {aclk, aresetn, go, awvalid, wvalid, bready, arvalid, rready, arm, have_base} = '0;
        {hcount, ecg_sample, awaddr, araddr, wdata, base} = '0;
        clk_en = 1'b1;
        wstrb = 4'hf;
        ctrl = 2'h3;
        exp_su = PPC_SETUP_RESET;
        error_cnt = 0;
        num_checks = 0;
        void'($urandom(37));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(PPC_OFS_CTRL, {PPC_RESP_OKAY, PPC_CTRL_RESET});
        axi_rd(4'hc, {PPC_RESP_SLVERR, 32'h0000_0000});
        axi_wr(4'hc, 32'hffff_ffff, PPC_RESP_SLVERR);
        axi_wr(PPC_OFS_STATUS, 32'hffff_ffff, PPC_RESP_OKAY);
        for (int i = 1; i <= 22; i++)
            send_cmd(5'(i), 12'($urandom % 300));
        // Strobe lane 0 off: control must keep its value
        wstrb <= 4'he;
        axi_wr(PPC_OFS_CTRL, 32'h0000_0000, PPC_RESP_OKAY);
        wstrb <= 4'hf;
        // Freeze mid-ramp: the echo comes back late by the frozen cycles
        fork
            send_cmd(5'h01, 12'h0c8);
            begin
                repeat (12) @(posedge aclk);
                clk_en <= 1'b0;
                repeat (9) @(posedge aclk);
                clk_en <= 1'b1;
                sq[0] = sq[0] + 12'h009;
            end
        join
        send_cmd(5'h05, 12'($urandom % 300));
        send_cmd(5'h05, 12'($urandom % 300));
        // Decode off: setup holds but conversion still runs
        axi_wr(PPC_OFS_CTRL, 32'h0000_0002, PPC_RESP_OKAY);
        ctrl = 2'h2;
        send_cmd(5'h0c, 12'($urandom % 300));
        // Echo off: setup latches, no echo may come back
        axi_wr(PPC_OFS_CTRL, 32'h0000_0001, PPC_RESP_OKAY);
        ctrl = 2'h1;
        send_cmd(5'h10, 12'($urandom % 300));
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        ctrl = 2'h3;
        arm = 1'b0;
        exp_su = PPC_SETUP_RESET;
        axi_rd(PPC_OFS_CTRL, {PPC_RESP_OKAY, PPC_CTRL_RESET});
        send_cmd(5'h14, 12'($urandom % 300));
        send_cmd(5'h07, 12'($urandom % 300));
        chk_echo(16'h0000, 16'(sq.size()));
        wrap_up();
    end
endmodule

/* File: ppc_echo_ramp.sv */
`timescale 1ns/1ps
module ppc_echo_ramp
(
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    input  wire logic                           clk_en,
    input  wire logic                           start,
    input  wire logic                           enable,
    input  wire logic [ppc_pkg::PPC_SAMPLE_W-1:0] sample,
    output logic                                echo,
    output logic                                busy,
    output logic [ppc_pkg::PPC_SAMPLE_W-1:0]    held
);
    import ppc_pkg::*;

    typedef enum logic [1:0]
    {
        PPC_ER_IDLE  = 2'b00,
        PPC_ER_RAMP  = 2'b01,
        PPC_ER_PULSE = 2'b11
    } ppc_er_e;

    ppc_er_e                   state;
    logic [PPC_SAMPLE_W-1:0]   ramp;
    logic [5:0]                pcnt;

    // ----------------------------------------------------------------
    // Output decode
    // ----------------------------------------------------------------
    assign echo = (state == PPC_ER_PULSE);
    assign busy = (state != PPC_ER_IDLE);

    // ----------------------------------------------------------------
    // Track, ramp and echo
    // ----------------------------------------------------------------
    // A new trigger restarts the ramp; a late echo would be worthless anyway
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= PPC_ER_IDLE;
            ramp  <= '0;
            pcnt  <= '0;
            held  <= '0;
        end
        else if (clk_en)
        begin
            if (start && enable)
            begin
                held  <= sample;
                ramp  <= sample;
                state <= PPC_ER_RAMP;
            end
            else
            begin
                case (state)
                    PPC_ER_IDLE:
                    begin
                        state <= PPC_ER_IDLE;
                    end
                    PPC_ER_RAMP:
                    begin
                        if (ramp == '0)
                        begin
                            state <= PPC_ER_PULSE;
                            pcnt  <= 6'(PPC_ECHO_CYC - 1);
                        end
                        else
                        begin
                            ramp <= ramp - 1'b1;
                        end
                    end
                    PPC_ER_PULSE:
                    begin
                        if (pcnt == '0)
                        begin
                            state <= PPC_ER_IDLE;
                        end
                        else
                        begin
                            pcnt <= pcnt - 1'b1;
                        end
                    end
                    default:
                    begin
                        state <= PPC_ER_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

/* File: ppc_host_model.sv */
`timescale 1ns/1ps
module ppc_host_model
(
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [4:0] count,
    input  wire logic       echo,
    output logic            pin,
    output logic [15:0]     meas,
    output logic            done
);
    logic [15:0] cyc;
    logic [15:0] t0;
    logic        echo_q;
    initial
    begin
        pin = 1'b0;
        cyc = 16'h0000;
        t0 = 16'h0000;
        echo_q = 1'b0;
    end
    // one train per command; link idles low between trains
    always
    begin
        @(posedge aclk);
        if (go)
        begin
            for (int i = 0; i < int'(count); i++)
            begin
                pin <= 1'b1;
                repeat (4) @(posedge aclk);
                pin <= 1'b0;
                repeat (4) @(posedge aclk);
            end
        end
    end
    // free-running counter times first rise to echo
    always @(posedge aclk)
    begin
        cyc <= cyc + 16'h0001;
        echo_q <= echo;
        done <= echo && !echo_q;
        if (go)
            t0 <= cyc;
        if (echo && !echo_q)
            meas <= cyc - t0;
    end
endmodule

/* File: ppc_pkg.sv */
package ppc_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned PPC_CLK_PERIOD_PS = 25_000;
    localparam int unsigned PPC_ONESHOT_US    = 1_500;
    localparam int unsigned PPC_ONESHOT_CYC   = (PPC_ONESHOT_US * 1_000_000) / PPC_CLK_PERIOD_PS;
    localparam int unsigned PPC_ECHO_PULSE_NS = 1_000;
    localparam int unsigned PPC_ECHO_CYC      = (PPC_ECHO_PULSE_NS * 1_000) / PPC_CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // Widths and pulse-count thresholds
    // ----------------------------------------------------------------
    localparam int unsigned PPC_SAMPLE_W    = 12;
    localparam int unsigned PPC_CNT_W       = 5;
    localparam int unsigned PPC_TMR_W       = 17;
    localparam logic [4:0]  PPC_CNT_PRESET  = 5'h01;
    localparam logic [4:0]  PPC_CNT_MAX     = 5'h1f;
    localparam logic [4:0]  PPC_CNT_LEAD_LO = 5'h04;
    localparam logic [4:0]  PPC_CNT_CAL1_LO = 5'h08;
    localparam logic [4:0]  PPC_CNT_CAL1_HI = 5'h0b;
    localparam logic [4:0]  PPC_CNT_COIL_LO = 5'h0c;
    localparam logic [4:0]  PPC_CNT_CAL2_LO = 5'h10;
    localparam logic [4:0]  PPC_CNT_CAL2_HI = 5'h13;
    localparam logic [4:0]  PPC_CNT_PADDLE  = 5'h14;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0]  PPC_OFS_CTRL    = 4'h0;
    localparam logic [3:0]  PPC_OFS_STATUS  = 4'h4;
    localparam logic [3:0]  PPC_OFS_SAMPLE  = 4'h8;
    localparam logic [31:0] PPC_CTRL_RESET  = 32'h0000_0003;
    localparam int unsigned PPC_CTRL_DEC_EN = 0;
    localparam int unsigned PPC_CTRL_ECHO_EN = 1;
    localparam int unsigned PPC_ST_SETUP_LSB = 0;
    localparam int unsigned PPC_ST_PLIM     = 7;
    localparam int unsigned PPC_ST_CNT_LSB  = 8;
    localparam int unsigned PPC_ST_BUSY     = 16;
    localparam int unsigned PPC_ST_ECHO     = 17;
    localparam logic [1:0]  PPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PPC_RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PPC_LEAD_III = 2'h0,
        PPC_LEAD_II  = 2'h1,
        PPC_LEAD_I   = 2'h2,
        PPC_LEAD_STD = 2'h3
    } ppc_lead_e;

    typedef struct packed
    {
        ppc_lead_e lead;
        logic      cal;
        logic      lead_coil;
        logic      paddle_coil;
        logic      smooth;
        logic      paddles;
    } ppc_setup_s;

    localparam ppc_setup_s PPC_SETUP_RESET = '{PPC_LEAD_III, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage
